// file: verilog/rai_pkg.sv
package rai_pkg;

	// Register map, byte addresses
	localparam logic [11:0] ALARM_GEN_CTRL_ADDR = 12'h0108;
	localparam logic [11:0] RAI_STATUS_ADDR     = 12'h010C;

	// Control register fields
	localparam int          ENFORCE_BIT         = 7;
	localparam int          TIMED_ENABLE_BIT    = 6;
	localparam int          FORMAT_HI_BIT       = 5;
	localparam int          FORMAT_LO_BIT       = 4;
	localparam logic [7:0]  CTRL_RESET          = 8'h00;
	localparam logic [7:0]  CTRL_WRITE_MASK     = 8'hF0;

	// Status register fields
	localparam int          STAT_ACTIVE_BIT     = 0;
	localparam int          STAT_HOLD_BIT       = 1;
	localparam int          STAT_GAP_BIT        = 2;

	// Format selector codes
	localparam logic [1:0]  FMT_OFF             = 2'h0;
	localparam logic [1:0]  FMT_BIT2            = 2'h1;
	localparam logic [1:0]  FMT_FS12            = 2'h2;
	localparam logic [1:0]  FMT_ALL_ONES        = 2'h3;

	// Framing select codes from the framing select register
	localparam logic [2:0]  FRAMING_SF          = 3'h5;
	localparam logic [2:0]  FRAMING_N           = 3'h6;

	// AXI responses
	localparam logic [1:0]  RESP_OKAY           = 2'h0;
	localparam logic [1:0]  RESP_DECERR         = 2'h3;

	// Timing: one T1 frame every 125 us, one second minimum
	localparam longint      ONE_SECOND_NS       = 1000000000;
	localparam longint      FRAME_PERIOD_NS     = 125000;
	localparam int          ONE_SECOND_FRAMES   =
		int'((ONE_SECOND_NS + FRAME_PERIOD_NS - 1) / FRAME_PERIOD_NS);
	localparam int          FRAME_CNT_W         = 16;

endpackage

// file: verilog/frame_timer.sv
`timescale 1ns/1ps
// Counts transmit frames from a restart; busy until the span has elapsed
module frame_timer #(
	parameter int unsigned FRAMES = 8000,
	parameter int unsigned WIDTH  = 16
) (
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic restart,
	input  wire logic frame_tick,
	output logic      busy,
	output logic      expired
);

	logic [WIDTH-1:0] count_q;
	logic             busy_q;
	logic             expired_q;

	// Restart wins over a tick in the same cycle so a retrigger is never short
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			count_q   <= '0;
			busy_q    <= 1'b0;
			expired_q <= 1'b0;
		end
		else
		begin
			expired_q <= 1'b0;
			if (restart)
			begin
				count_q <= WIDTH'(FRAMES);
				busy_q  <= 1'b1;
			end
			else if (busy_q && frame_tick)
			begin
				count_q <= count_q - WIDTH'(1);
				if (count_q == WIDTH'(1))
				begin
					busy_q    <= 1'b0;
					expired_q <= 1'b1;
				end
			end
		end
	end

	assign busy    = busy_q;
	assign expired = expired_q;

endmodule

// file: verilog/rai_tx_control.sv
`timescale 1ns/1ps
module rai_tx_control #(
	parameter int unsigned ONE_SECOND_FRAMES = rai_pkg::ONE_SECOND_FRAMES
) (
	input  wire logic        clk,
	input  wire logic        rst_b,
	// AXI4-Lite slave
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Transmit framer side
	input  wire logic        frame_tick,
	input  wire logic [2:0]  framing_select,
	input  wire logic        t1dm_mode,
	output logic             rai_active,
	output logic             rai_ds0_bit2_force,
	output logic             rai_fs_frame12_force,
	output logic             rai_ybit_force,
	output logic             rai_dl_enable,
	output logic             rai_dl_all_ones
);

	typedef enum logic [1:0] {IDLE, HOLD, RUN, GAP} rai_state_e;

	logic [7:0]  alarm_generation_control_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;
	rai_state_e  state_q;
	logic        request_q;
	logic        ds0_q;
	logic        fs12_q;
	logic        ybit_q;
	logic        dl_q;
	logic        dl_ones_q;

	logic        write_take;
	logic        read_take;
	logic        enforce;
	logic        timed_alarm_enable;
	logic [1:0]  rai_format_select;
	logic        request;
	logic        dur_restart;
	logic        gap_restart;
	logic        dur_busy;
	logic        dur_expired;
	logic        gap_busy;
	logic        abort_gap;
	logic        alarm_on;
	logic        esf;
	logic        sf;
	logic        n_mode;
	logic [31:0] status_word;

	assign enforce            = alarm_generation_control_q[rai_pkg::ENFORCE_BIT];
	assign timed_alarm_enable = alarm_generation_control_q[rai_pkg::TIMED_ENABLE_BIT];
	assign rai_format_select  = alarm_generation_control_q[rai_pkg::FORMAT_HI_BIT:
		rai_pkg::FORMAT_LO_BIT];

	// Write address and data are taken together, one write in flight at a time
	assign write_take    = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
	assign s_axi_awready = write_take;
	assign s_axi_wready  = write_take;
	assign read_take     = s_axi_arvalid && !rvalid_q;
	assign s_axi_arready = read_take;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			alarm_generation_control_q <= rai_pkg::CTRL_RESET;
		else if (write_take && s_axi_wstrb[0]
			&& s_axi_awaddr == rai_pkg::ALARM_GEN_CTRL_ADDR)
			alarm_generation_control_q <= s_axi_wdata[7:0] & rai_pkg::CTRL_WRITE_MASK;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			bvalid_q <= 1'b0;
			bresp_q  <= rai_pkg::RESP_OKAY;
		end
		else if (write_take)
		begin
			bvalid_q <= 1'b1;
			bresp_q  <= (s_axi_awaddr == rai_pkg::ALARM_GEN_CTRL_ADDR
				|| s_axi_awaddr == rai_pkg::RAI_STATUS_ADDR)
				? rai_pkg::RESP_OKAY : rai_pkg::RESP_DECERR;
		end
		else if (s_axi_bready)
			bvalid_q <= 1'b0;
	end

	assign status_word = {29'h0000_0000, state_q == GAP, state_q == HOLD, rai_active};

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= rai_pkg::RESP_OKAY;
		end
		else if (read_take)
		begin
			rvalid_q <= 1'b1;
			rresp_q  <= rai_pkg::RESP_OKAY;
			if (s_axi_araddr == rai_pkg::ALARM_GEN_CTRL_ADDR)
				rdata_q <= {24'h00_0000, alarm_generation_control_q};
			else if (s_axi_araddr == rai_pkg::RAI_STATUS_ADDR)
				rdata_q <= status_word;
			else
			begin
				rdata_q <= 32'h0000_0000;
				rresp_q <= rai_pkg::RESP_DECERR;
			end
		end
		else if (s_axi_rready)
			rvalid_q <= 1'b0;
	end

	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp  = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata  = rdata_q;
	assign s_axi_rresp  = rresp_q;

	// Alarm request level from software
	always_comb
	begin
		if (rai_format_select == rai_pkg::FMT_OFF)
			request = 1'b0;
		else if (enforce)
			request = timed_alarm_enable;
		else
			request = 1'b1;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			request_q <= 1'b0;
		else
			request_q <= request;
	end

	// A fresh request edge during an alarm restarts the one-second span
	assign dur_restart = request && ((state_q == IDLE) || (!request_q && state_q != GAP));
	// Gap measured from the end of the alarm, only with the rule on
	assign gap_restart = enforce && !dur_restart && (((state_q == HOLD) && dur_expired
		&& !request) || ((state_q == RUN) && !request) || abort_gap);

	frame_timer #(
		.FRAMES (ONE_SECOND_FRAMES),
		.WIDTH  (rai_pkg::FRAME_CNT_W)
	) u_duration_timer (
		.clk        (clk),
		.rst_b      (rst_b),
		.restart    (dur_restart),
		.frame_tick (frame_tick),
		.busy       (dur_busy),
		.expired    (dur_expired)
	);

	frame_timer #(
		.FRAMES (ONE_SECOND_FRAMES),
		.WIDTH  (rai_pkg::FRAME_CNT_W)
	) u_gap_timer (
		.clk        (clk),
		.rst_b      (rst_b),
		.restart    (gap_restart),
		.frame_tick (frame_tick),
		.busy       (gap_busy),
		.expired    ()
	);

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			state_q <= IDLE;
		else if (rai_format_select == rai_pkg::FMT_OFF && state_q != GAP)
			// Turning the selector off aborts at once, even inside the minimum
			state_q <= (state_q == IDLE || !enforce) ? IDLE : GAP;
		else
		begin
			unique case (state_q)
				IDLE:
					if (request)
						state_q <= HOLD;
				HOLD:
					if (dur_restart)
						state_q <= HOLD;
					else if (dur_expired)
						state_q <= request ? RUN : (enforce ? GAP : IDLE);
				RUN:
					if (dur_restart)
						state_q <= HOLD;
					else if (!request)
						state_q <= enforce ? GAP : IDLE;
				GAP:
					// Dropping the rule releases a pending gap
					if (!enforce || (!gap_busy && !gap_restart))
						state_q <= IDLE;
			endcase
		end
	end

	// Gap entry from an abort also needs the gap timer running
	assign abort_gap = enforce && rai_format_select == rai_pkg::FMT_OFF
		&& (state_q == HOLD || state_q == RUN);

	// Pattern follows the state for the whole alarm, so it never drops out at expiry
	assign alarm_on = state_q == HOLD || state_q == RUN;

	assign esf    = !framing_select[2];
	assign sf     = framing_select == rai_pkg::FRAMING_SF;
	assign n_mode = framing_select == rai_pkg::FRAMING_N && !t1dm_mode;

	// Format outputs follow the live selector and framing mode
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ds0_q     <= 1'b0;
			fs12_q    <= 1'b0;
			ybit_q    <= 1'b0;
			dl_q      <= 1'b0;
			dl_ones_q <= 1'b0;
		end
		else
		begin
			ds0_q     <= alarm_on && (sf || n_mode) && rai_format_select[0];
			fs12_q    <= alarm_on && sf && rai_format_select == rai_pkg::FMT_FS12;
			ybit_q    <= alarm_on && t1dm_mode && framing_select == rai_pkg::FRAMING_N;
			dl_q      <= alarm_on && esf;
			dl_ones_q <= alarm_on && esf && rai_format_select == rai_pkg::FMT_ALL_ONES;
		end
	end

	assign rai_active           = state_q == HOLD || state_q == RUN;
	assign rai_ds0_bit2_force   = ds0_q;
	assign rai_fs_frame12_force = fs12_q;
	assign rai_ybit_force       = ybit_q;
	assign rai_dl_enable        = dl_q;
	assign rai_dl_all_ones      = dl_ones_q;

endmodule

// file: tb/rai_checker.sv
`timescale 1ns/1ps
// Shadows the control word from bus traffic; frame counts are kept beside the ports
module rai_checker #(
	parameter int unsigned ONE_SECOND_FRAMES = 8000
) (
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0]  s_axi_wstrb,
	input wire logic        s_axi_bvalid,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        frame_tick,
	input wire logic [2:0]  framing_select,
	input wire logic        rai_active,
	input wire logic        rai_ds0_bit2_force,
	input wire logic        rai_fs_frame12_force,
	input wire logic        rai_ybit_force,
	input wire logic        rai_dl_enable,
	input wire logic        rai_dl_all_ones
);
	// Ticks seen only while active, so one frame of slack is allowed
	localparam int unsigned LO = ONE_SECOND_FRAMES - 1;
	logic [7:4]      c_q;
	logic [15:0]     on_q;
	logic [15:0]     gap_q;
	wire logic [1:0] sel = c_q[5:4];
	wire logic       mapped = s_axi_awaddr == rai_pkg::ALARM_GEN_CTRL_ADDR
		|| s_axi_awaddr == rai_pkg::RAI_STATUS_ADDR;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			c_q <= 4'h0;
		else if (s_axi_awvalid && s_axi_awready && s_axi_wstrb[0]
			&& s_axi_awaddr == rai_pkg::ALARM_GEN_CTRL_ADDR)
			c_q <= s_axi_wdata[7:4];
	end
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			on_q <= 16'h0000;
		else if (!rai_active)
			on_q <= 16'h0000;
		else if (frame_tick)
			on_q <= on_q + 16'h0001;
	end
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			gap_q <= 16'hFFFF;
		else if (rai_active)
			gap_q <= 16'h0000;
		else if (!c_q[7])
			gap_q <= 16'hFFFF;
		else if (frame_tick && gap_q != 16'hFFFF)
			gap_q <= gap_q + 16'h0001;
	end
	chk_min_hold: assert property (
		$fell(rai_active) && $past(sel) != 2'h0 |-> on_q >= LO)
		else $error("alarm shorter than minimum");
	chk_gap_kept: assert property (
		$rose(rai_active) |-> gap_q >= LO)
		else $error("alarm restarted inside gap");
	chk_rule_off: assert property (
		!rai_active && !c_q[7] && sel != 2'h0 |-> ##[1:4] rai_active)
		else $error("rule off alarm did not start");
	chk_enb_start: assert property (
		!rai_active && c_q[7] && c_q[6] && sel != 2'h0 && gap_q > ONE_SECOND_FRAMES
		|-> ##[1:4] rai_active)
		else $error("enabled alarm did not start");
	chk_enb_stop: assert property (
		(!rai_active && c_q[7] && !c_q[6]) [*3] |=> !rai_active)
		else $error("alarm started while disabled");
	chk_sel_off: assert property (
		(sel == 2'h0) [*4] |-> !rai_active)
		else $error("alarm with selector off");
	chk_fmt_sf: assert property (
		$past(rai_active) && $past(framing_select) == rai_pkg::FRAMING_SF
		|-> rai_fs_frame12_force == ($past(sel) == rai_pkg::FMT_FS12)
		&& rai_ds0_bit2_force == ($past(sel) == rai_pkg::FMT_BIT2
		|| $past(sel) == rai_pkg::FMT_ALL_ONES))
		else $error("wrong SF alarm format");
	chk_fmt_idle: assert property (
		!$past(rai_active) |-> !rai_ds0_bit2_force && !rai_fs_frame12_force)
		else $error("format forced while idle");
	chk_fmt_esf: assert property (
		$past(rai_active) && !$past(framing_select[2])
		|-> rai_dl_enable && !rai_ybit_force
		&& rai_dl_all_ones == ($past(sel) == rai_pkg::FMT_ALL_ONES))
		else $error("wrong ESF alarm format");
	chk_wr_resp: assert property (
		s_axi_awvalid && s_axi_awready |=> s_axi_bvalid && s_axi_bresp
		== ($past(mapped) ? rai_pkg::RESP_OKAY : rai_pkg::RESP_DECERR))
		else $error("bad write response");
endmodule

bind rai_tx_control rai_checker #(.ONE_SECOND_FRAMES(ONE_SECOND_FRAMES)) u_chk (.*);

// file: tb/far_end.sv
`timescale 1ns/1ps
// Remote terminal: paces frames and counts those that carry the alarm
module far_end #(
	parameter int P = 8
) (
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic rai_active,
	output logic      frame_tick,
	output int        rai_frames
);
	int n_q;
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			n_q <= 0;
			frame_tick <= 1'b0;
			rai_frames <= 0;
		end
		else
		begin
			n_q <= (n_q == P - 1) ? 0 : n_q + 1;
			frame_tick <= (n_q == P - 1);
			if (frame_tick && rai_active)
				rai_frames <= rai_frames + 1;
		end
	end
endmodule

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
	localparam int N = 4;
	localparam logic [11:0] CA = rai_pkg::ALARM_GEN_CTRL_ADDR;
	localparam logic [2:0] SF = rai_pkg::FRAMING_SF;
	localparam logic [2:0] NF = rai_pkg::FRAMING_N;
	// Any code with the top bit low frames ESF
	localparam logic [2:0] EF = 3'h0;
	typedef struct {logic [7:0] c; logic [2:0] fs; logic t; logic [5:0] o;} row_s;
	// Alarm, bit-2, frame-12, Y-bit, data link, all-ones after each control write
	row_s rows [12] = '{
		'{8'h1F, SF, 1'b0, 6'h30}, '{8'h20, SF, 1'b0, 6'h28}, '{8'h30, NF, 1'b0, 6'h30},
		'{8'h00, SF, 1'b0, 6'h00}, '{8'h40, SF, 1'b0, 6'h00}, '{8'h50, NF, 1'b0, 6'h30},
		'{8'h00, NF, 1'b0, 6'h00}, '{8'h30, EF, 1'b0, 6'h23}, '{8'h20, EF, 1'b0, 6'h22},
		'{8'h10, NF, 1'b1, 6'h24}, '{8'h00, NF, 1'b1, 6'h00}, '{8'hD0, SF, 1'b0, 6'h30}};
	logic [5:0] seen;
	logic clk = 1'b0, rst_b = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_bready = 1'b1, s_axi_rready = 1'b1, t1dm_mode = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0]  s_axi_wstrb = 4'h1;
	logic [2:0]  framing_select = 3'h5;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic frame_tick, rai_active, rai_ds0_bit2_force, rai_fs_frame12_force;
	logic rai_ybit_force, rai_dl_enable, rai_dl_all_ones;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic [31:0] s_axi_rdata, d;
	int rai_frames, bad_count = 0, checked = 0, cyc = 0, n, f0;
	rai_tx_control #(.ONE_SECOND_FRAMES(N)) u_dut (.*);
	far_end #(.P(8)) u_far (.*);
	always #2 clk = ~clk;
	assign seen = {rai_active, rai_ds0_bit2_force, rai_fs_frame12_force, rai_ybit_force,
		rai_dl_enable, rai_dl_all_ones};
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic ok, input string m);
		checked++;
		if (ok !== 1'b1)
		begin
			bad_count++;
			$display("MISMATCH t=%0t %s", $time, m);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do @(negedge clk); while (!(s_axi_awready && s_axi_wready));
		@(posedge clk);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		do @(negedge clk); while (!s_axi_bvalid);
		rs = s_axi_bresp;
		@(posedge clk);
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(negedge clk); while (!s_axi_arready);
		@(posedge clk);
		s_axi_arvalid <= 1'b0;
		do @(negedge clk); while (!s_axi_rvalid);
		v = s_axi_rdata;
		rs = s_axi_rresp;
		@(posedge clk);
	endtask
	// Bounded wait; the caller judges the cycle count in n
	task automatic wait_act(input logic v);
		n = 0;
		@(negedge clk);
		while (rai_active !== v && n < 200)
		begin
			@(negedge clk);
			n++;
		end
	endtask
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			bad_count++;
			complete_run();
		end
	end
	initial
	begin
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		rd(CA, d, r);
		chk(d === 32'h0000_0000 && r === rai_pkg::RESP_OKAY, "ctrl reset");
		rd(12'h200, d, r);
		chk(r === rai_pkg::RESP_DECERR, "unmapped read");
		wr(12'h200, 32'h0000_00F0, r);
		chk(r === rai_pkg::RESP_DECERR, "unmapped write");
		$display("map test done");
		foreach (rows[i])
		begin
			framing_select <= rows[i].fs;
			t1dm_mode <= rows[i].t;
			wr(CA, {24'h00_0000, rows[i].c}, r);
			repeat (6) @(negedge clk);
			chk(seen === rows[i].o, "row");
			rd(CA, d, r);
			chk(d === {24'h00_0000, rows[i].c & 8'hF0}, "readback");
			$display("row %0d done", i);
		end
		wr(CA, 32'h0000_00C0, r);
		wr(CA, 32'h0000_00D0, r);
		repeat (16) @(negedge clk);
		chk(rai_active === 1'b0, "gap held");
		wait_act(1'b1);
		chk(n < 40, "start after gap");
		f0 = rai_frames;
		wr(CA, 32'h0000_0090, r);
		@(negedge clk);
		chk(rai_active === 1'b1, "minimum hold");
		wait_act(1'b0);
		chk(rai_frames - f0 >= N - 1 && n < 60, "stop after minimum");
		wr(CA, 32'h0000_0010, r);
		wait_act(1'b1);
		chk(n < 6, "rule off ends gap");
		wr(CA, 32'h0000_0000, r);
		wait_act(1'b0);
		wr(CA, 32'h0000_0010, r);
		wait_act(1'b1);
		chk(n < 6, "no gap when rule off");
		// Reset in mid-alarm must drop everything at once
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (3) @(negedge clk);
		chk({seen, s_axi_bvalid, s_axi_rvalid} === 8'h00, "reset clears");
		@(posedge clk);
		rst_b <= 1'b1;
		rd(CA, d, r);
		chk(d === 32'h0000_0000 && rai_active === 1'b0, "ctrl after reset");
		$display("reset test done");
		$display("timing tests done");
		complete_run();
	end
endmodule
